//--- hw/tms_regs.vh
// Behaviour
// - Master input data sampled on input clock, PLL with loopback
// - Master outputs always driven by the PLL
// - Divided slave divides input clock, never faster
// - Multiplied slave uses synced high-speed clock
// - Slave modes sample input data on input clock
// - Slave default: PLL-only outputs stay off
// - Slave enable bit runs PLL-only outputs
// - PLL domain independent of switch domain
// - Master PLL locks to selected reference rate
// - Master output stream and all outputs from PLL
// - Internal loopback bit routes PLL timing back
// - Divided slave streams driven by input clock
// - Multiplied slave output stream from multiplied clock
// - Bypass passes input clock, multiplied multiplies
`ifndef TMS_REGS_VH
`define TMS_REGS_VH
// -------------------------------------------------
// Register byte offsets
// -------------------------------------------------
`define TMS_CTRL_OFS 8'h00
`define TMS_STAT_OFS 8'h04
`define TMS_PER_OFS 8'h08
// -------------------------------------------------
// Control field positions
// -------------------------------------------------
`define TMS_CTRL_OPM_LSB 0
`define TMS_CTRL_SLVEN_BIT 2
`define TMS_CTRL_LOOP_BIT 3
`define TMS_CTRL_REF_LSB 4
`define TMS_CTRL_RATE_LSB 6
`define TMS_CTRL_RST 32'h00000000
// -------------------------------------------------
// Operating mode codes
// -------------------------------------------------
`define TMS_OPM_MASTER 2'h0
`define TMS_OPM_DIV 2'h1
`define TMS_OPM_MULT 2'h3
// -------------------------------------------------
// Reference rate codes, rate pin codes
// -------------------------------------------------
`define TMS_REF_RATE_MAX 3'h6
`define TMS_RATE_PINS_4M 2'h3
// -------------------------------------------------
// Timing counts
// -------------------------------------------------
`define TMS_PER_W 12
`define TMS_FCNT_W 6
`endif

//--- hw/tms_clk_div.v
`timescale 1ns/1ps
`include "tms_regs.vh"
// -------------------------------------------------
// Divider chain: base tick to clocks and frame syncs
// -------------------------------------------------
module tms_clk_div #(
  parameter NCLK = 4,
  parameter NOFS = 3
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire tick_i,
  input wire frame_i,
  output wire [NCLK-1:0] clk_o,
  output reg [NCLK-1:0] fs_o,
  output reg [NOFS-1:0] ofs_o
);
  // Half-period counter, each bit a divided clock
  reg [NCLK-1:0] cnt_ff;
  // Half-periods since last frame, saturating
  reg [`TMS_FCNT_W-1:0] fcnt_ff;
  genvar k;

  // Counter advances per tick, frame realigns it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= {NCLK{1'b0}};
      fcnt_ff <= {`TMS_FCNT_W{1'b1}};
    end else if (tick_i) begin
      if (frame_i) begin
        cnt_ff <= {NCLK{1'b0}};
        fcnt_ff <= {`TMS_FCNT_W{1'b0}};
      end else begin
        cnt_ff <= cnt_ff + {{(NCLK-1){1'b0}}, 1'b1};
        if (fcnt_ff != {`TMS_FCNT_W{1'b1}}) begin
          fcnt_ff <= fcnt_ff + {{(`TMS_FCNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Clock k runs at base rate over two to the k
  assign clk_o = cnt_ff;

  // Frame syncs one period of their own clock wide
  generate
    for (k = 0; k < NCLK; k = k + 1) begin : g_fs
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          fs_o[k] <= 1'b0;
        end else begin
          fs_o[k] <= (fcnt_ff < (2 << k));
        end
      end
    end
    // Offset syncs follow right after the normal ones
    for (k = 0; k < NOFS; k = k + 1) begin : g_ofs
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ofs_o[k] <= 1'b0;
        end else begin
          ofs_o[k] <= (fcnt_ff >= (2 << k)) && (fcnt_ff < (4 << k));
        end
      end
    end
  endgenerate
endmodule // tms_clk_div

//--- hw/tms_timing_mode.v
`timescale 1ns/1ps
`include "tms_regs.vh"
// -------------------------------------------------
// Timing mode select with Wishbone registers
// -------------------------------------------------
module tms_timing_mode (
  input wire sys_clk_i,
  input wire resetn_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Pins from outside the clock domain
  input wire input_clock_i,
  input wire input_frame_sync_i,
  input wire [1:0] input_clock_rate_pins_i,
  input wire oscillator_present_pin_i,
  // Embedded PLL outputs, own domain
  input wire pll_clock_i,
  input wire pll_frame_sync_i,
  // Controls toward the embedded PLL
  output reg pll_enable_o,
  output reg [1:0] pll_ref_select_o,
  output reg [2:0] pll_ref_rate_o,
  // Generated timing
  output wire [3:0] switch_output_clocks_o,
  output wire [3:0] output_frame_syncs_o,
  output wire [2:0] offset_frame_syncs_o,
  output reg pll_only_clock_a_o,
  output reg pll_only_clock_b_o,
  output reg pll_only_frame_sync_o,
  // Stream strobes
  output reg stream_out_strobe_o,
  output reg stream_in_sample_o
);
  // -------------------------------------------------
  // Reset release
  // -------------------------------------------------
  // Two-stage release of the async reset
  reg [1:0] rst_sync_ff;
  wire rst_n;

  // Release after two edges
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // -------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------
  // Inputs: ck, fp, pll ck, pll fp, rate0, rate1, osc
  localparam NSYN = 7;
  wire [NSYN-1:0] raw_in;
  reg [NSYN-1:0] syn1_ff;
  reg [NSYN-1:0] syn2_ff;
  reg [NSYN-1:0] syn3_ff;
  // Accepted level once stages two and three agree
  reg [NSYN-1:0] lvl_ff;
  // Previous accepted level for edge finding
  reg [NSYN-1:0] lvl_d_ff;
  genvar i;

  assign raw_in = {oscillator_present_pin_i, input_clock_rate_pins_i,
                   pll_frame_sync_i, pll_clock_i, input_frame_sync_i,
                   input_clock_i};

  // Three flops per input, agreement filter
  generate
    for (i = 0; i < NSYN; i = i + 1) begin : g_syn
      always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          syn1_ff[i] <= 1'b0;
          syn2_ff[i] <= 1'b0;
          syn3_ff[i] <= 1'b0;
          lvl_ff[i] <= 1'b0;
          lvl_d_ff[i] <= 1'b0;
        end else begin
          syn1_ff[i] <= raw_in[i];
          syn2_ff[i] <= syn1_ff[i];
          syn3_ff[i] <= syn2_ff[i];
          if (syn2_ff[i] == syn3_ff[i]) begin
            lvl_ff[i] <= syn3_ff[i];
          end
          lvl_d_ff[i] <= lvl_ff[i];
        end
      end
    end
  endgenerate

  // Edges of the accepted levels
  wire ck_rise = lvl_ff[0] & ~lvl_d_ff[0];
  wire ck_fall = ~lvl_ff[0] & lvl_d_ff[0];
  wire fp_edge = lvl_ff[1] ^ lvl_d_ff[1];
  wire pk_rise = lvl_ff[2] & ~lvl_d_ff[2];
  wire pk_fall = ~lvl_ff[2] & lvl_d_ff[2];
  wire pf_edge = lvl_ff[3] ^ lvl_d_ff[3];
  wire [1:0] rate_pins = lvl_ff[5:4];
  wire osc_present = lvl_ff[6];

  // -------------------------------------------------
  // Control register
  // -------------------------------------------------
  reg [31:0] ctrl_ff;
  wire [1:0] operating_mode_field = ctrl_ff[`TMS_CTRL_OPM_LSB +: 2];
  wire slv_pll_en = ctrl_ff[`TMS_CTRL_SLVEN_BIT];
  wire int_loop = ctrl_ff[`TMS_CTRL_LOOP_BIT];
  wire [1:0] ref_sel = ctrl_ff[`TMS_CTRL_REF_LSB +: 2];
  wire [2:0] ref_rate = ctrl_ff[`TMS_CTRL_RATE_LSB +: 3];
  // Reserved code 10 runs as master
  wire is_div = (operating_mode_field == `TMS_OPM_DIV);
  wire is_mult = (operating_mode_field == `TMS_OPM_MULT);
  wire is_master = ~is_div & ~is_mult;

  // -------------------------------------------------
  // Wishbone slave
  // -------------------------------------------------
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [31:0] stat_val;
  reg [`TMS_PER_W-1:0] period_ff;
  reg [31:0] nxt_rdat;
  integer b;

  // Read data selection by offset
  always @* begin
    case (wb_adr_i)
      `TMS_CTRL_OFS: begin
        nxt_rdat = ctrl_ff;
      end
      `TMS_STAT_OFS: begin
        nxt_rdat = stat_val;
      end
      `TMS_PER_OFS: begin
        nxt_rdat = {{(32-`TMS_PER_W){1'b0}}, period_ff};
      end
      default: begin
        // Unmapped reads as zero
        nxt_rdat = 32'h00000000;
      end
    endcase
  end

  // One-cycle ack, byte-lane writes
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_ff <= `TMS_CTRL_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= nxt_rdat;
      end
      if (wb_req && wb_we_i && (wb_adr_i == `TMS_CTRL_OFS)) begin
        for (b = 0; b < 4; b = b + 1) begin
          if (wb_sel_i[b]) begin
            ctrl_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
      end
    end
  end

  // -------------------------------------------------
  // PLL control outputs
  // -------------------------------------------------
  // Enable, reference and rate toward the PLL
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pll_enable_o <= 1'b0;
      pll_ref_select_o <= 2'h0;
      pll_ref_rate_o <= 3'h0;
    end else begin
      pll_enable_o <= is_master | slv_pll_en;
      pll_ref_select_o <= ref_sel;
      if (ref_rate > `TMS_REF_RATE_MAX) begin
        pll_ref_rate_o <= `TMS_REF_RATE_MAX;
      end else begin
        pll_ref_rate_o <= ref_rate;
      end
    end
  end

  // -------------------------------------------------
  // Input clock period measurement
  // -------------------------------------------------
  // System cycles since last input clock rise
  reg [`TMS_PER_W-1:0] pcnt_ff;
  // Multiplied tick spacing and its counter
  reg [`TMS_PER_W-1:0] mcnt_ff;
  wire [`TMS_PER_W-1:0] sat = {`TMS_PER_W{1'b1}};
  // eight times for 4M, else four times
  wire [`TMS_PER_W-1:0] mult_gap_raw = (rate_pins == `TMS_RATE_PINS_4M) ?
                                       (period_ff >> 3) : (period_ff >> 2);
  wire [`TMS_PER_W-1:0] mult_gap = (mult_gap_raw == {`TMS_PER_W{1'b0}}) ?
                                   {{(`TMS_PER_W-1){1'b0}}, 1'b1} : mult_gap_raw;
  wire mult_tick;

  // Period capture at each input clock rise
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_ff <= {`TMS_PER_W{1'b0}};
      period_ff <= {`TMS_PER_W{1'b0}};
    end else if (ck_rise) begin
      period_ff <= pcnt_ff + {{(`TMS_PER_W-1){1'b0}}, 1'b1};
      pcnt_ff <= {`TMS_PER_W{1'b0}};
    end else if (pcnt_ff != sat) begin
      pcnt_ff <= pcnt_ff + {{(`TMS_PER_W-1){1'b0}}, 1'b1};
    end
  end

  // -------------------------------------------------
  // Multiplied clock generator
  // -------------------------------------------------
  // high-speed tick resynced to input clock
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mcnt_ff <= {`TMS_PER_W{1'b0}};
    end else if (ck_rise || mult_tick) begin
      mcnt_ff <= {`TMS_PER_W{1'b0}};
    end else begin
      mcnt_ff <= mcnt_ff + {{(`TMS_PER_W-1){1'b0}}, 1'b1};
    end
  end
  assign mult_tick = ck_rise | (mcnt_ff + {{(`TMS_PER_W-1){1'b0}}, 1'b1} >= mult_gap);

  // -------------------------------------------------
  // Timing source selection
  // -------------------------------------------------
  reg base_tick;
  reg base_frame;
  reg out_edge;
  reg in_edge;

  // Pick base tick, frame and stream strobes
  always @* begin
    base_tick = 1'b0;
    base_frame = 1'b0;
    out_edge = 1'b0;
    in_edge = 1'b0;
    if (is_master) begin
      base_tick = pk_rise | pk_fall;
      base_frame = pf_edge & lvl_ff[3];
      out_edge = pk_fall;
      if (int_loop) begin
        in_edge = pk_rise;
      end else begin
        in_edge = ck_rise;
      end
    end else if (is_div) begin
      base_tick = ck_rise | ck_fall;
      base_frame = fp_edge & lvl_ff[1];
      out_edge = ck_fall;
      in_edge = ck_rise;
    end else begin
      base_tick = mult_tick;
      base_frame = fp_edge & lvl_ff[1];
      out_edge = mult_tick;
      in_edge = ck_rise;
    end
  end

  // Stream strobes registered
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stream_out_strobe_o <= 1'b0;
      stream_in_sample_o <= 1'b0;
    end else begin
      stream_out_strobe_o <= out_edge;
      stream_in_sample_o <= in_edge;
    end
  end

  // -------------------------------------------------
  // Switch output clock chain
  // -------------------------------------------------
  // Frame held until the next base tick
  reg frame_pend_ff;

  // Latch frame, consume it with a tick
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_pend_ff <= 1'b0;
    end else if (base_tick) begin
      // Tick uses any frame now, no second realign
      frame_pend_ff <= 1'b0;
    end else if (base_frame) begin
      frame_pend_ff <= 1'b1;
    end
  end

  // Divider chain for clocks and frame syncs
  tms_clk_div #(
    .NCLK(4),
    .NOFS(3)
  ) u_tms_clk_div (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .tick_i(base_tick),
    .frame_i(frame_pend_ff | base_frame),
    .clk_o(switch_output_clocks_o),
    .fs_o(output_frame_syncs_o),
    .ofs_o(offset_frame_syncs_o)
  );

  // -------------------------------------------------
  // PLL-only outputs
  // -------------------------------------------------
  // Second PLL-only clock at half rate
  reg pll_half_ff;
  wire pll_on = is_master | slv_pll_en;

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pll_half_ff <= 1'b0;
      pll_only_clock_a_o <= 1'b0;
      pll_only_clock_b_o <= 1'b0;
      pll_only_frame_sync_o <= 1'b0;
    end else begin
      if (pk_rise) begin
        pll_half_ff <= ~pll_half_ff;
      end
      pll_only_clock_a_o <= pll_on & lvl_ff[2];
      pll_only_clock_b_o <= pll_on & pll_half_ff;
      pll_only_frame_sync_o <= pll_on & lvl_ff[3];
    end
  end

  // -------------------------------------------------
  // Status word
  // -------------------------------------------------
  // Live mode and pin view
  assign stat_val = {24'h000000, osc_present, rate_pins, pll_on,
                     lvl_ff[0], is_mult, is_div, is_master};
endmodule // tms_timing_mode

//--- testbench/tms_far_side.sv
`timescale 1ns/1ps
// ----
// Backplane clock source and PLL outputs
// ----
module tms_far_side #(
  parameter IN_HALF = 40,
  parameter PLL_HALF = 56
) (
  output logic in_clk_o,
  output wire in_fs_o,
  output logic pll_clk_o,
  output wire pll_fs_o
);
  logic [2:0] in_cnt = 3'h0; // Input clocks in frame
  logic [2:0] pll_cnt = 3'h0; // PLL clocks in frame
  logic in_fs = 1'h0; // Input frame mark
  logic pll_fs = 1'h0; // PLL frame mark
  assign in_fs_o = in_fs;
  assign pll_fs_o = pll_fs;
  // Free running input clock
  initial begin
    in_clk_o = 1'h0;
    #3;
    forever #(IN_HALF) in_clk_o = ~in_clk_o;
  end
  initial begin
    pll_clk_o = 1'h0;
    #5;
    forever #(PLL_HALF) pll_clk_o = ~pll_clk_o;
  end
  // Frame mark every eighth rise
  always @(posedge in_clk_o) begin
    in_cnt <= in_cnt + 3'h1;
    in_fs <= in_cnt == 3'h7;
  end
  always @(posedge pll_clk_o) begin
    pll_cnt <= pll_cnt + 3'h1;
    pll_fs <= pll_cnt == 3'h7;
  end
endmodule // tms_far_side

//--- testbench/tms_timing_mode_asserts.sv
`timescale 1ns/1ps
`include "tms_regs.vh"
// ----
// Mode control checker
// ----
module tms_timing_mode_asserts (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire pll_enable_o,
  input wire [1:0] pll_ref_select_o,
  input wire [2:0] pll_ref_rate_o,
  input wire [3:0] switch_output_clocks_o,
  input wire pll_only_clock_a_o,
  input wire pll_only_clock_b_o,
  input wire pll_only_frame_sync_o,
  input wire stream_in_sample_o
);
  reg [8:0] ctrl_ff; // Shadow of control bits
  reg [3:0] age_ff; // Cycles since control write
  wire wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00;
  wire settled = age_ff == 4'hF;
  wire [2:0] exp_rate = (ctrl_ff[8:6] > `TMS_REF_RATE_MAX) ? `TMS_REF_RATE_MAX : ctrl_ff[8:6];
  // Track control writes per byte lane
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_ff <= 9'h000;
      age_ff <= 4'h0;
    end else if (wr_ctrl) begin
      ctrl_ff <= {wb_sel_i[1] ? wb_dat_i[8] : ctrl_ff[8],
                  wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_ff[7:0]};
      age_ff <= 4'h0;
    end else if (!settled) begin
      age_ff <= age_ff + 4'h1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a pulse after request");
  property p_unmapped;
    s_req and (!wb_we_i && wb_adr_i == 8'h0C) |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pll_en;
    settled |-> pll_enable_o == (!ctrl_ff[0] || ctrl_ff[2]);
  endproperty
  a_pll_en: assert property (p_pll_en) else $error("pll enable wrong");
  property p_ref_sel;
    settled |-> pll_ref_select_o == ctrl_ff[5:4];
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("ref select wrong");
  property p_ref_rate;
    settled |-> pll_ref_rate_o == exp_rate;
  endproperty
  a_ref_rate: assert property (p_ref_rate) else $error("ref rate wrong");
  property p_pll_off;
    settled && ctrl_ff[0] && !ctrl_ff[2]
      |-> !pll_only_clock_a_o && !pll_only_clock_b_o && !pll_only_frame_sync_o;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll only output active");
  property p_div_rate;
    settled && ctrl_ff[1:0] == `TMS_OPM_DIV && $changed(switch_output_clocks_o[0])
      |=> $stable(switch_output_clocks_o[0]) [*3];
  endproperty
  a_div_rate: assert property (p_div_rate) else $error("divided clock too fast");
  property p_in_pulse;
    settled && ctrl_ff[0] && stream_in_sample_o |=> !stream_in_sample_o [*3];
  endproperty
  a_in_pulse: assert property (p_in_pulse) else $error("input samples too close");
endmodule // tms_timing_mode_asserts

//--- testbench/tms_timing_mode_tb.sv
`timescale 1ns/1ps
`include "tms_regs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module tms_timing_mode_tb;
  logic sys_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [1:0] input_clock_rate_pins_i = 2'h0;
  logic oscillator_present_pin_i = 1'h0;
  logic ext_lp = 1'h0; // External loopback select
  int fail_count = 0;
  int samples_checked = 0;
  int t0, t1, si, pb; // Edge counts of one window
  int so, f0, o0, pa, pf; // Strobe, frame and PLL-only counts
  wire [31:0] wb_dat_o;
  wire wb_ack_o, pll_enable_o, pll_only_clock_a_o, pll_only_clock_b_o, pll_only_frame_sync_o;
  wire stream_out_strobe_o, stream_in_sample_o, far_clk, far_fs, pll_clock_i, pll_frame_sync_i;
  wire [1:0] pll_ref_select_o;
  wire [2:0] pll_ref_rate_o, offset_frame_syncs_o;
  wire [3:0] switch_output_clocks_o, output_frame_syncs_o;
  // Watched levels for the measuring window
  wire [6:0] mv = {pll_only_frame_sync_o, pll_only_clock_a_o, offset_frame_syncs_o[0],
                   output_frame_syncs_o[0], pll_only_clock_b_o, switch_output_clocks_o[1:0]};
  wire input_clock_i = ext_lp ? switch_output_clocks_o[0] : far_clk;
  wire input_frame_sync_i = ext_lp ? output_frame_syncs_o[0] : far_fs;
  always #4 sys_clk_i = ~sys_clk_i;
  tms_far_side u_tms_far_side (.in_clk_o(far_clk), .in_fs_o(far_fs), .pll_clk_o(pll_clock_i),
    .pll_fs_o(pll_frame_sync_i));
  tms_timing_mode u_tms_timing_mode (
    .sys_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .input_clock_i, .input_frame_sync_i, .input_clock_rate_pins_i,
    .oscillator_present_pin_i, .pll_clock_i, .pll_frame_sync_i, .pll_enable_o,
    .pll_ref_select_o, .pll_ref_rate_o, .switch_output_clocks_o, .output_frame_syncs_o,
    .offset_frame_syncs_o, .pll_only_clock_a_o, .pll_only_clock_b_o, .pll_only_frame_sync_o,
    .stream_out_strobe_o, .stream_in_sample_o);
  // ----
  // Bus and measuring tasks
  // ----
  task end_sim;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task xfer(input [7:0] a, input w, input [31:0] d, input [3:0] s, output [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_o !== 1'h1);
    `CHK(n, 2)
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task rd_chk(input [7:0] a, input [31:0] m, input [31:0] e);
    logic [31:0] q;
    xfer(a, 1'h0, 32'h0, 4'hF, q);
    `CHK(q & m, e)
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    logic [31:0] q;
    xfer(a, 1'h1, d, s, q);
    repeat (30) @(posedge sys_clk_i);
  endtask
  task measure;
    logic [6:0] p;
    t0 = 0;
    t1 = 0;
    si = 0;
    pb = 0;
    so = 0;
    f0 = 0;
    o0 = 0;
    pa = 0;
    pf = 0;
    p = mv;
    repeat (560) begin
      @(posedge sys_clk_i);
      t0 += int'(mv[0] != p[0]);
      t1 += int'(mv[1] != p[1]);
      pb += int'(mv[2] != p[2]);
      f0 += int'(mv[3] & ~p[3]);
      o0 += int'(mv[4] & ~p[4]);
      pa += int'(mv[5] != p[5]);
      pf += int'(mv[6] & ~p[6]);
      si += int'(stream_in_sample_o === 1'h1);
      so += int'(stream_out_strobe_o === 1'h1);
      p = mv;
    end
  endtask
  task rng(input int v, input int lo, input int hi);
    `CHK(v >= lo && v <= hi, 1'h1)
  endtask
  // ----
  // Scenarios
  // ----
  task t_regs;
    rd_chk(8'h00, 32'hFFFFFFFF, 32'h0);
    rd_chk(8'h04, 32'hFFFFFFF7, 32'h11);
    rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0);
    wr(8'h04, 32'hFFFFFFFF, 4'hF);
    wr(8'h00, 32'h3, 4'h0);
    rd_chk(8'h00, 32'hFFFFFFFF, 32'h0);
    rd_chk(8'h04, 32'hFFFFFFF7, 32'h11);
    rd_chk(8'h08, 32'hFFFFFFFF, 32'hA);
    oscillator_present_pin_i <= 1'h1;
    input_clock_rate_pins_i <= `TMS_RATE_PINS_4M;
    repeat (10) @(posedge sys_clk_i);
    rd_chk(8'h04, 32'hE0, 32'hE0);
    input_clock_rate_pins_i <= 2'h0;
  endtask
  task t_modes;
    logic [2:0] st [4];
    st = '{3'h1, 3'h2, 3'h1, 3'h4};
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, i, 4'h1);
      rd_chk(8'h04, 32'h7, {29'h0, st[i]});
      `CHK(pll_enable_o, i[0] == 1'h0)
    end
  endtask
  task t_ref;
    wr(8'h00, 32'h1E0, 4'h3);
    `CHK(pll_ref_rate_o, `TMS_REF_RATE_MAX)
    `CHK(pll_ref_select_o, 2'h2)
    wr(8'h00, 32'h0, 4'h2);
    `CHK(pll_ref_rate_o, 3'h3)
    `CHK(pll_ref_select_o, 2'h2)
  endtask
  task t_master;
    wr(8'h00, 32'h8, 4'h3);
    measure;
    rng(t0, 78, 82);
    rng(si, 39, 41);
    rng(so, 39, 41);
    rng(f0, 4, 6);
    rng(o0, 4, 6);
    ext_lp <= 1'h1;
    wr(8'h00, 32'h2, 4'h1);
    measure;
    rng(si, 38, 42);
    rng(t0, 78, 82);
    ext_lp <= 1'h0;
  endtask
  task t_slave;
    wr(8'h00, 32'h1, 4'h1);
    measure;
    rng(t0, 110, 114);
    rng(t1, 54, 58);
    rng(si, 55, 57);
    rng(so, 55, 57);
    rng(f0, 6, 8);
    rng(o0, 6, 8);
    `CHK(pb, 0)
    `CHK(pa, 0)
    `CHK(pf, 0)
    `CHK(pll_enable_o, 1'h0)
    wr(8'h00, 32'h5, 4'h1);
    measure;
    rng(pb, 38, 42);
    rng(pa, 78, 82);
    rng(pf, 4, 6);
    rng(t0, 110, 114);
    `CHK(pll_enable_o, 1'h1)
  endtask
  task t_mult;
    int a;
    wr(8'h00, 32'h3, 4'h1);
    measure;
    a = t0;
    rng(t0, 115, 560);
    rng(so, t0 - 1, t0 + 1);
    rng(si, 55, 57);
    input_clock_rate_pins_i <= `TMS_RATE_PINS_4M;
    repeat (30) @(posedge sys_clk_i);
    measure;
    rng(t0, a + 1, 560);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'h1;
    repeat (2) @(posedge sys_clk_i);
    t_regs;
    t_modes;
    t_ref;
    t_master;
    t_slave;
    t_mult;
    end_sim;
  end
  // Hang guard
  initial begin
    #400000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim;
  end
endmodule // tms_timing_mode_tb
bind tms_timing_mode tms_timing_mode_asserts u_tms_timing_mode_asserts (
  .sys_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .pll_enable_o, .pll_ref_select_o, .pll_ref_rate_o,
  .switch_output_clocks_o, .pll_only_clock_a_o, .pll_only_clock_b_o, .pll_only_frame_sync_o,
  .stream_in_sample_o);
